//--- design/adc_sequencer_control.sv
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"

module adc_sequencer_control (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic second_priority_request,
  input wire logic wake_timer,
  input wire logic timer_zero,
  input wire adc_seq_pkg::core_data_t core_data,
  output adc_seq_pkg::core_ctrl_t core_ctrl,
  output logic irq
);

  // ==========================================================
  // Registered state.
  logic [15:0] ctrl_q, ctrl_d;
  logic [7:0] res_q [4], res_d [4];
  logic [1:0] sts_q, sts_d, ien_q, ien_d;
  logic [1:0] sts_set;
  adc_seq_pkg::seq_state_t st_q, st_d;
  logic [3:0] ph_q, ph_d;
  logic [1:0] chan_q, chan_d, slot_q, slot_d, cnt_q, cnt_d;
  logic [4:0] coarse_q, coarse_d;
  logic [31:0] rdata_d;
  logic ack_q, ack_d;
  logic irq_d;
  adc_seq_pkg::core_ctrl_t cc_d;
  logic tick, running, trig, ctl_wr, wr_go, rd_go, en;
  logic pre_run;
  logic [1:0] src;
  logic [7:0] conv_word;
  adc_seq_pkg::conv_mode_t mode;

  // ==========================================================
  // Limitations.
  // Trigger inputs are taken as one-cycle pulses already in this clock domain.
  // A trigger level held high restarts the conversion on every cycle.
  // Phase lengths are fixed counts of prescaler ticks, so a slower divide
  // trades conversion speed for settling time on the analog side.
  // Status bit 1 records aborts only; software clears it like the done bit.
  // The reserved bits, the done flag and bit 2 ignore writes.

  assign en = ctrl_q[`BIT_ENABLE];
  assign mode = adc_seq_pkg::conv_mode_t'(ctrl_q[`MODE_HI:`MODE_LO]);
  assign running = (st_q != adc_seq_pkg::ST_IDLE);
  // One wait state: the answer comes on the cycle after the request is seen.
  // A write lands on the edge at which waitrequest is sampled low.
  assign wr_go = avs_write && ack_q;
  // Read data is registered on the first edge, so it stands while waitrequest is low.
  assign rd_go = avs_read && !ack_q;
  assign ctl_wr = wr_go && (avs_address == `OFS_CONTROL);
  // A control write is judged by the source it writes, so switching away from
  // write-start does not fire a stray conversion.
  assign src = ctl_wr ? avs_writedata[`TRIG_HI:`TRIG_LO] : ctrl_q[`TRIG_HI:`TRIG_LO];
  // The prescaler restarts with every trigger so a fresh conversion gets full phases.
  assign pre_run = running && !trig;
  // Each result joins the held coarse part with the fine part at the end of fine.
  assign conv_word = {coarse_q, core_data.fine_bits};

  // ==========================================================
  // Trigger selection. Inputs are treated as synchronous pulses.
  always_comb begin
    case (src)
      2'b00: trig = ctl_wr && avs_writedata[`BIT_ENABLE];
      2'b01: trig = second_priority_request;
      2'b10: trig = wake_timer;
      2'b11: trig = timer_zero;
      default: trig = 1'b0;
    endcase
    // A disabled converter only starts from a write that sets enable in the same word.
    trig = trig && (en || ctl_wr) && !(ctl_wr && !avs_writedata[`BIT_ENABLE]);
  end

  // Divided clock for the phase counters; it is held at zero while idle.
  clock_prescaler #(
    .CNT_W(7)
  ) u_prescaler (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .run(pre_run),
    .sel(ctrl_q[`DIV_HI:`DIV_LO]),
    .tick(tick)
  );

  // ==========================================================
  // Sequencer: auto-zero, sample, coarse, fine, then next conversion.
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    chan_d = chan_q;
    slot_d = slot_q;
    cnt_d = cnt_q;
    coarse_d = coarse_q;
    res_d = res_q;
    sts_d = sts_q;
    sts_set = 2'h0;
    ctrl_d = ctrl_q;
    if (ctl_wr) begin
      // Reserved bits and the done flag are not writable; done clears on any write.
      ctrl_d = avs_writedata[15:0] & `CONTROL_WMASK;
      if (!en && !avs_writedata[`BIT_ENABLE]) begin
        ctrl_d = ctrl_q & ~(16'h1 << `BIT_DONE);
      end
    end
    if (trig) begin
      // A new trigger always wins over a running conversion.
      st_d = adc_seq_pkg::ST_AUTOZERO;
      ph_d = '0;
      chan_d = ctl_wr ? avs_writedata[`CH_HI:`CH_LO] : ctrl_q[`CH_HI:`CH_LO];
      slot_d = '0;
      cnt_d = '0;
    end else if (!en) begin
      // Disable drops the sequence; results keep their last completed values.
      st_d = adc_seq_pkg::ST_IDLE;
    end else if (running && tick) begin
      ph_d = ph_q + 4'h1;
      case (st_q)
        // Auto-zero the comparators before each sample.
        adc_seq_pkg::ST_AUTOZERO: begin
          if (ph_q == `AZ_TICKS - 4'h1) begin
            st_d = adc_seq_pkg::ST_SAMPLE;
            ph_d = '0;
          end
        end
        // Track the selected input.
        adc_seq_pkg::ST_SAMPLE: begin
          if (ph_q == `SAMPLE_TICKS - 4'h1) begin
            st_d = adc_seq_pkg::ST_COARSE;
            ph_d = '0;
          end
        end
        // Resolve the upper five bits on the coarse ladder.
        adc_seq_pkg::ST_COARSE: begin
          if (ph_q == `COARSE_TICKS - 4'h1) begin
            coarse_d = core_data.coarse_bits;
            st_d = adc_seq_pkg::ST_FINE;
            ph_d = '0;
          end
        end
        // Resolve the lower three bits, store the result and pick the next step.
        adc_seq_pkg::ST_FINE: begin
          if (ph_q == `FINE_TICKS - 4'h1) begin
            ph_d = '0;
            // Repeat mode stores by slot, the rest by channel.
            if (mode == adc_seq_pkg::MODE_REPEAT4) begin
              res_d[slot_q] = conv_word;
            end else begin
              res_d[chan_q] = conv_word;
            end
            // The count wraps, so in continuous mode the flag comes on every fourth result.
            cnt_d = cnt_q + 2'h1;
            if (ctrl_q[`BIT_IRQ_EN] && ((!ctrl_q[`BIT_IRQ_TIMING] && cnt_q == 2'h0) ||
                (ctrl_q[`BIT_IRQ_TIMING] && cnt_q == 2'h3))) begin
              ctrl_d[`BIT_DONE] = 1'b1;
              sts_set[0] = 1'b1;
            end
            st_d = adc_seq_pkg::ST_AUTOZERO;
            case (mode)
              // Same channel again into the next slot.
              adc_seq_pkg::MODE_REPEAT4: begin
                slot_d = slot_q + 2'h1;
                if (slot_q == 2'h3) begin
                  st_d = adc_seq_pkg::ST_IDLE;
                end
              end
              // One result, then stop.
              adc_seq_pkg::MODE_SINGLE: begin
                st_d = adc_seq_pkg::ST_IDLE;
              end
              // Next channel upward, wrapping, for four results in all.
              adc_seq_pkg::MODE_SCAN_ONCE: begin
                chan_d = chan_q + 2'h1;
                slot_d = slot_q + 2'h1;
                if (slot_q == 2'h3) begin
                  st_d = adc_seq_pkg::ST_IDLE;
                end
              end
              // Continuous scan never stops by itself.
              default: begin
                chan_d = chan_q + 2'h1;
              end
            endcase
          end
        end
        default: st_d = adc_seq_pkg::ST_IDLE;
      endcase
    end
    // Status bit 1 records an abort by retrigger or by disable.
    if (running && (trig || !en)) begin
      sts_set[1] = 1'b1;
    end
    // Hardware set wins over a software clear in the same cycle: the clear
    // acts on the old bits and the new events are merged in afterwards.
    if (wr_go && avs_address == `OFS_IRQ_CLEAR) begin
      sts_d = sts_q & ~avs_writedata[1:0];
    end
    sts_d = sts_d | sts_set;
  end

  // ==========================================================
  // Bus answer and interrupt enable.
  always_comb begin
    // Waitrequest drops for exactly one cycle per request.
    ack_d = (avs_read || avs_write) && !ack_q;
    ien_d = ien_q;
    rdata_d = 32'h0000_0000;
    if (wr_go && avs_address == `OFS_IRQ_ENABLE) begin
      ien_d = avs_writedata[1:0];
    end
    if (rd_go) begin
      case (avs_address)
        `OFS_CONTROL: rdata_d = {16'h0000, ctrl_q};
        `OFS_IRQ_STATUS: rdata_d = {30'h0, sts_q};
        `OFS_IRQ_ENABLE: rdata_d = {30'h0, ien_q};
        `OFS_RESULT0, `OFS_RESULT1, `OFS_RESULT2, `OFS_RESULT3: begin
          // Results read as zero while the converter is disabled.
          rdata_d = en ? {24'h0, res_q[2'(avs_address - `OFS_RESULT0)]} : 32'h0;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    // Interrupt level follows the next status, so it registers with the bit.
    irq_d = |(sts_d & ien_d);
  end

  // ==========================================================
  // Core strobes come from the next state, so once registered they line up
  // with the state register and never lag a phase change.
  always_comb begin
    cc_d.channel = chan_d;
    cc_d.autozero = (st_d == adc_seq_pkg::ST_AUTOZERO);
    cc_d.sample = (st_d == adc_seq_pkg::ST_SAMPLE);
    cc_d.coarse = (st_d == adc_seq_pkg::ST_COARSE);
    cc_d.fine = (st_d == adc_seq_pkg::ST_FINE);
  end

  // Register stage; clock enable freezes everything.
  // Every top-level output comes straight from one of these flops.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q <= `CONTROL_RESET;
      for (int i = 0; i < 4; i++) begin
        res_q[i] <= 8'h00;
      end
      sts_q <= 2'h0;
      ien_q <= 2'h0;
      st_q <= adc_seq_pkg::ST_IDLE;
      ph_q <= 4'h0;
      chan_q <= 2'h0;
      slot_q <= 2'h0;
      cnt_q <= 2'h0;
      coarse_q <= 5'h00;
      ack_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
      core_ctrl <= '0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      res_q <= res_d;
      sts_q <= sts_d;
      ien_q <= ien_d;
      st_q <= st_d;
      ph_q <= ph_d;
      chan_q <= chan_d;
      slot_q <= slot_d;
      cnt_q <= cnt_d;
      coarse_q <= coarse_d;
      ack_q <= ack_d;
      avs_readdata <= rdata_d;
      avs_waitrequest <= !ack_d;
      irq <= irq_d;
      core_ctrl <= cc_d;
    end
  end

endmodule : adc_sequencer_control
`default_nettype wire

//--- design/adc_seq_params.svh
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// ==========================================================
// Register word offsets on the Avalon-MM slave.
`define OFS_CONTROL 4'h0
`define OFS_RESULT0 4'h1
`define OFS_RESULT1 4'h2
`define OFS_RESULT2 4'h3
`define OFS_RESULT3 4'h4
`define OFS_IRQ_STATUS 4'h5
`define OFS_IRQ_CLEAR 4'h6
`define OFS_IRQ_ENABLE 4'h7
// ==========================================================
// Control word field positions.
`define BIT_ENABLE 15
`define BIT_DONE 12
`define BIT_IRQ_TIMING 11
`define BIT_IRQ_EN 10
`define TRIG_HI 9
`define TRIG_LO 8
`define DIV_HI 7
`define DIV_LO 5
`define MODE_HI 4
`define MODE_LO 3
`define CH_HI 1
`define CH_LO 0
`define CONTROL_RESET 16'h0000
`define CONTROL_WMASK 16'h8FFB
// ==========================================================
// Divider step, phase lengths in divided clocks.
`define DIV_STEP 8
`define AZ_TICKS 4'h2
`define SAMPLE_TICKS 4'h2
`define COARSE_TICKS 4'h2
`define FINE_TICKS 4'h2
`define IRQ_BITS 2

`endif

//--- design/adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic [1:0] {
    MODE_REPEAT4 = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_SCAN_ONCE = 2'b10,
    MODE_SCAN_LOOP = 2'b11
  } conv_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_AUTOZERO = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_COARSE = 3'b011,
    ST_FINE = 3'b100
  } seq_state_t;

  // Request towards the analog core.
  typedef struct packed {
    logic [1:0] channel;
    logic autozero;
    logic sample;
    logic coarse;
    logic fine;
  } core_ctrl_t;

  // Answer from the analog core.
  typedef struct packed {
    logic [4:0] coarse_bits;
    logic [2:0] fine_bits;
  } core_data_t;

endpackage : adc_seq_pkg

//--- design/clock_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"

// ==========================================================
// Prescaler: emits one tick every 8*(sel+1) enabled clocks.
module clock_prescaler #(
  parameter int CNT_W = 7
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic tick_d;
  logic [CNT_W-1:0] limit;

  // Ratio 8 for code 0 up to 64 for code 7.
  assign limit = CNT_W'((32'(sel) + 32'd1) * `DIV_STEP - 32'd1);

  // Count restarts whenever the sequencer is not running.
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!run) begin
      cnt_d = '0;
    end else if (cnt_q >= limit) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      tick <= tick_d;
    end
  end

endmodule : clock_prescaler
`default_nettype wire

//--- verification/adc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Analog core stand-in.
module adc_core_model (
  input wire logic mclk,
  input wire adc_seq_pkg::core_ctrl_t ctrl,
  output adc_seq_pkg::core_data_t data,
  output logic [2:0] cnt
);
  logic fine_q;
  initial begin
    cnt = 3'h0;
    data = 8'h00;
    fine_q = 1'b0;
  end
  // Data carries channel and conversion count; junk outside coarse and fine.
  always @(posedge mclk) begin
    fine_q <= ctrl.fine;
    if (ctrl.fine && !fine_q) cnt <= cnt + 3'h1;
    if (ctrl.coarse) data <= {ctrl.channel, cnt, 3'h5};
    else if (!ctrl.fine) data <= ~data;
  end
endmodule : adc_core_model
`default_nettype wire

//--- verification/adc_seq_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Port checks of the sequencer.
module adc_seq_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic second_priority_request,
  input wire logic wake_timer,
  input wire logic timer_zero,
  input wire adc_seq_pkg::core_data_t core_data,
  input wire adc_seq_pkg::core_ctrl_t core_ctrl,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Bus answers one cycle after a request, for one cycle.
  property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no bus answer");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  // Unmapped places read as zero.
  property p_unm; avs_read && !avs_waitrequest && avs_address[3] |-> avs_readdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  // Phases are exclusive and keep their order.
  property p_oneph; $onehot0(core_ctrl[3:0]); endproperty
  a_oneph: assert property (p_oneph) else $error("two phases at once");
  property p_az; $rose(core_ctrl.sample) |-> $past(core_ctrl.autozero); endproperty
  a_az: assert property (p_az) else $error("sample without autozero");
  property p_cf; $rose(core_ctrl.fine) |-> $past(core_ctrl.coarse); endproperty
  a_cf: assert property (p_cf) else $error("fine without coarse");
  // Longest phase is two ticks of the divide-by-64 clock.
  property p_len; $rose(core_ctrl.sample) |-> ##[1:140] !core_ctrl.sample; endproperty
  a_len: assert property (p_len) else $error("sample phase too long");
  // Clearing the enable stops the core within three cycles, for at least eight.
  property p_dis;
    avs_write && !avs_waitrequest && avs_address == 4'h0 && !avs_writedata[15]
      |=> ##[0:2] (core_ctrl[3:0] == 4'h0) [*8];
  endproperty
  a_dis: assert property (p_dis) else $error("core busy while disabled");
endmodule : adc_seq_chk
`default_nettype wire

//--- verification/test_adc_sequencer_control.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Register-level test of the sequencer.
module test_adc_sequencer_control;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] trg = 3'h0;
  logic irq;
  logic [2:0] cnt;
  logic [2:0] b;
  adc_seq_pkg::core_data_t core_data;
  adc_seq_pkg::core_ctrl_t core_ctrl;
  int n_fail = 0;
  int n_tests = 0;
  // Clock at 200 MHz.
  always #2.5 mclk = ~mclk;
  adc_core_model u_core (.mclk(mclk), .ctrl(core_ctrl), .data(core_data), .cnt(cnt));
  adc_sequencer_control u_dut (.mclk(mclk), .reset(reset), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .second_priority_request(trg[0]), .wake_timer(trg[1]),
    .timer_zero(trg[2]), .core_data(core_data), .core_ctrl(core_ctrl), .irq(irq));
  function automatic logic [31:0] cv(input int c, input int n);
    return {24'h0, 2'(c), 3'(n), 3'h5};
  endfunction : cv
  task automatic results;
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One bus cycle; the extra edge keeps two requests from meeting in one step.
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
    chk(32'(n), 32'h2);
  endtask : xfer
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic clr;
    wr(4'h6, 32'h3);
    rd(4'h5, 32'h0);
  endtask : clr
  // Start a conversion by write or pulse, then time it to the interrupt.
  task automatic run(input logic [31:0] ctl, input int s, input int cyc);
    int n;
    wr(4'h0, ctl);
    if (s > 0) begin
      trg <= 3'(1 << (s - 1));
      @(posedge mclk);
      trg <= 3'h0;
    end
    if (s == 3) begin
      repeat (30) @(posedge mclk);
      trg <= 3'h4;
      @(posedge mclk);
      trg <= 3'h0;
    end
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n >= cyc - 4 && n <= cyc + 40), 32'h1);
  endtask : run
  // Main sequence.
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    wr(4'h7, 32'h1);
    for (int c = 0; c < 4; c++) begin
      b = cnt;
      run(32'h8408 | 32'(c) | (32'(2 * c + 1) << 5), 0, 64 * (2 * c + 2));
      rd(4'(c + 1), cv(c, b));
      rd(4'h0, 32'h9408 | 32'(c) | (32'(2 * c + 1) << 5));
      clr;
    end
    wr(4'h0, 32'hF500);
    rd(4'h0, 32'h8500);
    b = cnt;
    run(32'h8C02, 0, 256);
    for (int k = 0; k < 4; k++) rd(4'(k + 1), cv(2, b + k));
    clr;
    b = cnt;
    run(32'h8C13, 0, 256);
    for (int k = 0; k < 4; k++) rd(4'((3 + k) % 4 + 1), cv((3 + k) % 4, b + k));
    clr;
    for (int s = 1; s < 4; s++) begin
      b = cnt;
      run(32'h8428 | 32'(s) | (32'(s) << 8), s, 128);
      rd(4'(s + 1), cv(s, b));
      chk(32'(cnt), 32'(3'(b + 3'h1)));
      rd(4'h5, (s == 3) ? 32'h3 : 32'h1);
      clr;
    end
    wr(4'h7, 32'h0);
    wr(4'h0, 32'h8408);
    repeat (100) @(posedge mclk);
    chk(32'(irq), 32'h0);
    rd(4'h5, 32'h1);
    clr;
    wr(4'h7, 32'h1);
    wr(4'h0, 32'h8008);
    repeat (100) @(posedge mclk);
    rd(4'h5, 32'h0);
    wr(4'h0, 32'h8018);
    repeat (100) @(posedge mclk);
    wr(4'h0, 32'h0);
    b = cnt;
    rd(4'h1, 32'h0);
    repeat (200) @(posedge mclk);
    chk(32'(cnt), 32'(b));
    rd(4'h5, 32'h2);
    results;
  end
  // Cut a hang short well past the expected run.
  initial begin
    #100000;
    n_fail++;
    results;
  end
endmodule : test_adc_sequencer_control
bind adc_sequencer_control adc_seq_chk u_chk (.mclk(mclk), .reset(reset), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .second_priority_request(second_priority_request), .wake_timer(wake_timer), .timer_zero(timer_zero),
  .core_data(core_data), .core_ctrl(core_ctrl), .irq(irq));
`default_nettype wire
